/* freq_pkg.sv */
// Shared constants, register map and carrier types for the fractional tuning logic
package freq_pkg;

	// Bus and field widths
	localparam int ADDR_W = 5;
	localparam int DATA_W = 24;
	localparam int INT_W = 19;
	localparam int FRAC_W = 24;
	localparam int STEP_W = 14;
	localparam int DIV_W = INT_W + 1;

	// Register indices on the register port
	localparam logic [ADDR_W-1:0] ADDR_INT = 5'h03;
	localparam logic [ADDR_W-1:0] ADDR_FRAC = 5'h04;
	localparam logic [ADDR_W-1:0] ADDR_MODCFG = 5'h06;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 5'h0C;

	// Modulator configuration fields
	localparam int CFG_FRAC_EN_BIT = 11;
	localparam int CFG_BYPASS_BIT = 7;
	localparam int CFG_SEED_LSB = 0;
	localparam int SEED_SEL_W = 2;

	// Reset values
	localparam logic [INT_W-1:0] INT_RST = 19'h0_0014;
	localparam logic [FRAC_W-1:0] FRAC_RST = 24'h00_0000;
	localparam logic [STEP_W-1:0] STEP_RST = 14'h0000;
	localparam logic [DATA_W-1:0] MODCFG_RST = 24'h00_0002;

	// Start phase seeds selected by the seed field
	localparam logic [FRAC_W-1:0] SEED_ZERO = 24'h00_0000;
	localparam logic [FRAC_W-1:0] SEED_HALF = 24'h80_0000;
	localparam logic [FRAC_W-1:0] SEED_RAND_A = 24'hB2_D05E;
	localparam logic [FRAC_W-1:0] SEED_RAND_B = 24'h50_F5A3;

	// One register port request: write or read strobe, index and data
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_s;

endpackage : freq_pkg

/* exact_residue_acc.sv */
// Secondary accumulator that spreads the exact-mode residue over the step count
`timescale 1ns/1ps
module exact_residue_acc #(
	parameter int STEP_W = 14
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_clear,
	input wire logic [STEP_W-1:0] i_step_count,
	input wire logic [STEP_W-1:0] i_residue,
	output logic o_borrow
);
	import freq_pkg::*;

	typedef struct packed {
		logic [STEP_W-1:0] acc;
		logic borrow;
	} res_state_s;

	res_state_s st_reg;
	res_state_s st_next;
	logic [STEP_W:0] sum;

	assign sum = {1'b0, st_reg.acc} + {1'b0, i_residue};

	// Modulo-M residue walk; a wrap asks the main accumulator to take one less
	always_comb begin
		st_next = st_reg;
		if (i_clear || i_step_count == '0) begin
			st_next.acc = '0;
			st_next.borrow = 1'b0;
		end else if (sum >= {1'b0, i_step_count}) begin
			st_next.acc = STEP_W'(sum - {1'b0, i_step_count});
			st_next.borrow = 1'b1;
		end else begin
			st_next.acc = sum[STEP_W-1:0];
			st_next.borrow = 1'b0;
		end
	end

	// State register
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_borrow = st_reg.borrow;

	// Exact mode off never corrects the main step
	a_borrow_off_exact: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_step_count == '0 || i_clear) |=> !o_borrow)
		else $error("borrow raised with exact mode off");

	// Residue stays inside the step count modulus
	a_residue_in_range: assert property (@(posedge i_core_clk) disable iff (i_rst)
		($past(i_step_count) != '0 && !$past(i_clear) && $past(i_residue) < $past(i_step_count))
		|-> st_reg.acc < $past(i_step_count))
		else $error("residue accumulator left its modulus");

endmodule : exact_residue_acc

/* exact_frac_tuner.sv */
// Frequency word registers and full-modulus fractional modulator with exact mode
`timescale 1ns/1ps
module exact_frac_tuner #(
	parameter int INT_W = 19,
	parameter int FRAC_W = 24,
	parameter int STEP_W = 14
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire freq_pkg::reg_req_s i_reg_req,
	output logic [freq_pkg::DATA_W-1:0] o_reg_rdata,
	output logic [INT_W:0] o_divide_ratio,
	output logic [FRAC_W-1:0] o_phase_acc,
	output logic o_frac_active,
	output logic o_exact_active
);
	import freq_pkg::*;

	typedef struct packed {
		logic [INT_W-1:0] integer_divide_field;
		logic [FRAC_W-1:0] fractional_word;
		logic [STEP_W-1:0] exact_step_count;
		logic [DATA_W-1:0] mod_cfg;
		logic [FRAC_W-1:0] phase_acc;
		logic [INT_W:0] divide;
		logic [DATA_W-1:0] rdata;
		logic frac_active;
		logic exact_active;
	} tuner_state_s;

	tuner_state_s st_reg;
	tuner_state_s st_next;
	logic wr_int;
	logic wr_frac;
	logic wr_cfg;
	logic wr_step;
	logic borrow;
	logic [FRAC_W+STEP_W-1:0] frac_times_step;
	logic [FRAC_W-1:0] step_inc;
	logic [FRAC_W:0] acc_sum;
	logic [FRAC_W-1:0] seed;
	logic [SEED_SEL_W-1:0] seed_sel;

	// Write decode on the register port
	assign wr_int = i_reg_req.wr && i_reg_req.addr == ADDR_INT;
	assign wr_frac = i_reg_req.wr && i_reg_req.addr == ADDR_FRAC;
	assign wr_cfg = i_reg_req.wr && i_reg_req.addr == ADDR_MODCFG;
	assign wr_step = i_reg_req.wr && i_reg_req.addr == ADDR_STEP;

	// Residue left by the rounded-up word: frac*M mod 2^14, below M for a well-formed word
	assign frac_times_step = st_reg.fractional_word * st_reg.exact_step_count;
	assign step_inc = st_reg.fractional_word - FRAC_W'(borrow);
	assign acc_sum = {1'b0, st_reg.phase_acc} + {1'b0, step_inc};

	// Seed picked by the seed field of the configuration register
	assign seed_sel = st_reg.mod_cfg[CFG_SEED_LSB +: SEED_SEL_W];
	always_comb begin
		case (seed_sel)
			2'h0: seed = SEED_ZERO;
			2'h1: seed = SEED_HALF;
			2'h2: seed = SEED_RAND_A;
			default: seed = SEED_RAND_B;
		endcase
	end

	// The correction walk restarts with every new word so the exact period lines up
	exact_residue_acc #(
		.STEP_W(STEP_W)
	) u_residue (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_clear(wr_frac || wr_step || !st_reg.frac_active),
		.i_step_count(st_reg.exact_step_count),
		.i_residue(frac_times_step[STEP_W-1:0]),
		.o_borrow(borrow)
	);

	// Register file, modulator step and readback
	always_comb begin
		st_next = st_reg;
		if (wr_int) begin
			st_next.integer_divide_field = i_reg_req.wdata[INT_W-1:0];
		end
		if (wr_frac) begin
			st_next.fractional_word = i_reg_req.wdata[FRAC_W-1:0];
		end
		if (wr_cfg) begin
			st_next.mod_cfg = i_reg_req.wdata;
		end
		if (wr_step) begin
			st_next.exact_step_count = i_reg_req.wdata[STEP_W-1:0];
		end
		st_next.frac_active = st_next.mod_cfg[CFG_FRAC_EN_BIT]
			&& !st_next.mod_cfg[CFG_BYPASS_BIT];
		// Registered so the status port comes straight from a flip-flop
		st_next.exact_active = st_next.frac_active && st_next.exact_step_count != '0;
		// A new word restarts the accumulator from the seed, never a shortened length
		if (wr_frac) begin
			st_next.phase_acc = seed;
			st_next.divide = {1'b0, st_reg.integer_divide_field};
		end else if (st_reg.frac_active) begin
			st_next.phase_acc = acc_sum[FRAC_W-1:0];
			st_next.divide = {1'b0, st_reg.integer_divide_field}
				+ {{INT_W{1'b0}}, acc_sum[FRAC_W]};
		end else begin
			st_next.divide = {1'b0, st_reg.integer_divide_field};
		end
		// Unmapped indices read as zero
		if (i_reg_req.rd) begin
			case (i_reg_req.addr)
				ADDR_INT: st_next.rdata = DATA_W'(st_reg.integer_divide_field);
				ADDR_FRAC: st_next.rdata = DATA_W'(st_reg.fractional_word);
				ADDR_MODCFG: st_next.rdata = st_reg.mod_cfg;
				ADDR_STEP: st_next.rdata = DATA_W'(st_reg.exact_step_count);
				default: st_next.rdata = '0;
			endcase
		end
	end

	// State register
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_reg.integer_divide_field <= INT_RST;
			st_reg.fractional_word <= FRAC_RST;
			st_reg.exact_step_count <= STEP_RST;
			st_reg.mod_cfg <= MODCFG_RST;
			st_reg.phase_acc <= '0;
			st_reg.divide <= '0;
			st_reg.rdata <= '0;
			st_reg.frac_active <= 1'b0;
			st_reg.exact_active <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign o_reg_rdata = st_reg.rdata;
	assign o_divide_ratio = st_reg.divide;
	assign o_phase_acc = st_reg.phase_acc;
	assign o_frac_active = st_reg.frac_active;
	assign o_exact_active = st_reg.exact_active;

	// Seed reload steps: a word write, then the seed on the accumulator
	sequence s_frac_write;
		wr_frac;
	endsequence

	property p_seed_reload;
		@(posedge i_core_clk) disable iff (i_rst)
		s_frac_write ##1 1'b1 |-> st_reg.phase_acc == $past(seed);
	endproperty

	a_seed_reload: assert property (p_seed_reload)
		else $error("seed not loaded after new fractional word");

	// Accumulator wraps at the full 24-bit modulus
	a_full_modulus: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(st_reg.frac_active && !wr_frac) |=> st_reg.phase_acc == $past(acc_sum[FRAC_W-1:0]))
		else $error("accumulator did not step by the word");

	// Divide ratio is integer plus the modulator carry
	a_carry_ratio: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(st_reg.frac_active && !wr_frac && acc_sum[FRAC_W])
		|=> st_reg.divide == $past(st_reg.integer_divide_field) + 1'b1)
		else $error("carry not added to divide ratio");

	// Bypassed modulator gives the plain integer ratio
	a_int_mode_ratio: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!st_reg.frac_active |=> st_reg.divide == {1'b0, $past(st_reg.integer_divide_field)})
		else $error("integer mode ratio wrong");

	// Word-only channel change leaves the integer and step count alone
	a_channel_keep: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(wr_frac ##1 !i_reg_req.wr) |=> $stable(st_reg.integer_divide_field)
			&& $stable(st_reg.exact_step_count))
		else $error("channel change disturbed other settings");

	// Step count write lands in the step count register
	a_step_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
		wr_step |=> st_reg.exact_step_count == $past(i_reg_req.wdata[STEP_W-1:0]))
		else $error("step count write lost");

	// Readback of the integer register
	a_read_back: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_reg_req.rd && i_reg_req.addr == ADDR_INT)
		|=> st_reg.rdata == DATA_W'($past(st_reg.integer_divide_field)))
		else $error("integer register readback wrong");

	// Exact mode off means no correction: one step is exactly the word
	a_exact_off_step: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(st_reg.exact_step_count == '0 && st_reg.frac_active && !wr_frac ##1
			(st_reg.exact_step_count == '0 && st_reg.frac_active && !wr_frac))
		|=> st_reg.phase_acc == FRAC_W'($past(st_reg.phase_acc) + $past(st_reg.fractional_word)))
		else $error("uncorrected step differs from word");

endmodule : exact_frac_tuner

/* tb_top.sv */
// Register-level bench for the exact fractional tuner
`timescale 1ns/1ps
module tb_top;
	import freq_pkg::*;

	localparam longint NI = 'h2D;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	reg_req_s req = '0;
	logic [DATA_W-1:0] rdata;
	logic [INT_W:0] divide;
	logic [FRAC_W-1:0] acc;
	logic [FRAC_W-1:0] hold;
	logic frac_on;
	logic exact_on;
	int fails = 0;
	int checked = 0;
	int cycles = 0;
	logic [FRAC_W-1:0] seeds [4] = '{SEED_ZERO, SEED_HALF, SEED_RAND_A, SEED_RAND_B};

	exact_frac_tuner u_exact_frac_tuner (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_reg_req(req),
		.o_reg_rdata(rdata),
		.o_divide_ratio(divide),
		.o_phase_acc(acc),
		.o_frac_active(frac_on),
		.o_exact_active(exact_on)
	);

	// 25 ns comparison clock
	initial begin
		forever #12.5 i_core_clk = ~i_core_clk;
	end

	// Hang guard, well above the three long windows
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			test_done();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Strobe is dropped at the taking edge, so back-to-back calls leave one idle cycle
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge i_core_clk);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= d;
		@(posedge i_core_clk);
		req.wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge i_core_clk);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge i_core_clk);
		req.rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask : rd

	// Over n steps the carries and the end phase follow from n*w less b borrowed units
	task automatic window(input int n, input logic [FRAC_W-1:0] w, input longint b);
		longint total;
		longint carries;
		total = longint'(acc) + longint'(n) * longint'(w) - b;
		carries = 0;
		repeat (n) begin
			@(posedge i_core_clk);
			#1;
			carries += longint'(divide) - NI;
		end
		check(acc, total[23:0]);
		check(carries, total >> 24);
	endtask : window

	task automatic test_done();
		$display("Counts: %0d checked, %0d failed", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done

	initial begin
		repeat (4) @(posedge i_core_clk);
		#1;
		check({rdata, divide}, '0);
		check({acc, frac_on, exact_on}, '0);
		@(posedge i_core_clk);
		i_rst <= 1'b0;
		// Reset values, width masking and an unmapped index
		rd(ADDR_INT, INT_RST);
		rd(ADDR_FRAC, FRAC_RST);
		rd(ADDR_STEP, STEP_RST);
		rd(ADDR_MODCFG, MODCFG_RST);
		wr(5'h1F, 24'hFF_FFFF);
		rd(5'h1F, 24'h00_0000);
		wr(ADDR_INT, 24'hFF_FFFF);
		rd(ADDR_INT, 24'h07_FFFF);
		wr(ADDR_STEP, 24'hFF_FFFF);
		rd(ADDR_STEP, 24'h00_3FFF);
		wr(ADDR_STEP, 24'h00_0000);
		$display("register test done");
		// Integer mode: phase frozen, divide follows the integer ratio
		wr(ADDR_INT, 24'h00_002D);
		wr(ADDR_MODCFG, 24'h00_0082);
		hold = acc;
		repeat (4) @(posedge i_core_clk);
		#1;
		check({acc, divide, frac_on}, {hold, 20'h0_002D, 1'b0});
		// Enable with bypass still set must stay in integer mode
		wr(ADDR_MODCFG, 24'h00_0882);
		check({acc, frac_on}, {hold, 1'b0});
		$display("integer test done");
		// Each seed is reloaded by a new fractional word
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_MODCFG, 24'h00_0800 | 24'(s));
			wr(ADDR_FRAC, 24'h40_0000);
			check({acc, frac_on, exact_on}, {seeds[s], 2'b10});
		end
		$display("seed test done");
		// Plain binary modulus keeps the quantization residue
		wr(ADDR_FRAC, 24'h93_EAAB);
		window(3072, 24'h93_EAAB, 0);
		$display("binary modulus test done");
		// Exact mode on one target, then a channel change by the word alone
		wr(ADDR_STEP, 24'h00_0C00);
		check(exact_on, 1'b1);
		wr(ADDR_FRAC, 24'h93_8000);
		repeat (8) @(posedge i_core_clk);
		#1;
		window(3072, 24'h93_8000, 0);
		wr(ADDR_FRAC, 24'h93_EAAB);
		repeat (8) @(posedge i_core_clk);
		#1;
		window(3072, 24'h93_EAAB, 1024);
		check(exact_on, 1'b1);
		rd(ADDR_INT, 24'h00_002D);
		rd(ADDR_STEP, 24'h00_0C00);
		$display("exact test done");
		test_done();
	end
endmodule : tb_top
